/* File: hdl/sbsd_map.vh */
// Register map, field positions and timing counts of the datapath
`ifndef SBSD_MAP_VH
`define SBSD_MAP_VH
// ---------------------------------------------------------------
// Register word indices (byte address = 4 * index)
// ---------------------------------------------------------------
`define SBSD_REG_CTRL 4'h0
`define SBSD_REG_OPA 4'h1
`define SBSD_REG_OPB 4'h2
`define SBSD_REG_COUNT 4'h3
`define SBSD_REG_DIDX 4'h4
`define SBSD_REG_FLAGS 4'h5
`define SBSD_REG_RESULT 4'h6
`define SBSD_REG_STATUS 4'h7
`define SBSD_REG_CMD 4'h8
// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define SBSD_CT_OPC 7:0
`define SBSD_CT_REG 10:8
`define SBSD_CT_OP32 12
`define SBSD_CT_AD32 13
`define SBSD_CT_PROT 14
`define SBSD_CT_CPL 16:15
`define SBSD_CT_REP 18:17
`define SBSD_CT_MEMDST 19
`define SBSD_CTRL_RST 32'h00000000
// ---------------------------------------------------------------
// Flag bit positions
// ---------------------------------------------------------------
`define SBSD_F_CARRY 0
`define SBSD_F_PARITY 2
`define SBSD_F_AUX 4
`define SBSD_F_ZERO 6
`define SBSD_F_SIGN 7
`define SBSD_F_DIR 10
`define SBSD_F_OVER 11
`define SBSD_FLAGS_MASK 32'h00000CD5
// ---------------------------------------------------------------
// Sizes, repeat modes, fault codes, timing
// ---------------------------------------------------------------
`define SBSD_SZ_BYTE 2'h0
`define SBSD_SZ_WORD 2'h1
`define SBSD_SZ_DWORD 2'h2
`define SBSD_SH_LEFT 2'h0
`define SBSD_SH_SAR 2'h1
`define SBSD_SH_SHR 2'h2
`define SBSD_REP_EQ 2'h1
`define SBSD_REP_NE 2'h2
`define SBSD_FLT_NONE 3'h0
`define SBSD_FLT_GP 3'h1
`define SBSD_FLT_STACK 3'h2
`define SBSD_FLT_PAGE 3'h3
`define SBSD_FLT_ALIGN 3'h4
`define SBSD_FLT_REAL 3'h5
`define SBSD_REAL_VECTOR 8'h0D
`define SBSD_REAL_LIMIT 33'h00000FFFF
`define SBSD_SEG_EXTRA 3'h0
`define SBSD_SCAN_CLOCKS 3'h6
`endif

/* File: hdl/sbsd_shifter.v */
// Stepwise shifter with carry and overflow generation
`timescale 1ns/1ps
`include "sbsd_map.vh"
module sbsd_shifter (
  input wire [31:0] operand,
  input wire [1:0] size,
  input wire [1:0] kind,
  input wire [4:0] count,
  input wire carryIn,
  input wire overflowIn,
  output reg [31:0] result,
  output reg carryOut,
  output reg overflowOut
);
  // ----------------
  // Size helpers
  // ----------------
  function [4:0] topIdx;
    input [1:0] sz;
    begin
      topIdx = (sz == `SBSD_SZ_BYTE) ? 5'h07 : (sz == `SBSD_SZ_WORD) ? 5'h0F : 5'h1F;
    end
  endfunction
  function [31:0] szMask;
    input [1:0] sz;
    begin
      szMask = (sz == `SBSD_SZ_BYTE) ? 32'h000000FF :
        (sz == `SBSD_SZ_WORD) ? 32'h0000FFFF : 32'hFFFFFFFF;
    end
  endfunction
  // ----------------
  // One step per count, unrolled; count already masked to 5 bits
  // ----------------
  integer i;
  reg [31:0] v; // Working value
  reg c; // Working carry
  reg msb; // Sign bit kept on arithmetic right
  reg [4:0] top; // Top bit index for size
  always @* begin
    top = topIdx(size);
    v = operand & szMask(size);
    c = carryIn;
    msb = 1'b0;
    for (i = 0; i < 32; i = i + 1) begin
      if (i < count) begin
        if (kind == `SBSD_SH_LEFT) begin
          c = v[top];
          v = (v << 1) & szMask(size);
        end else begin
          c = v[0];
          msb = (kind == `SBSD_SH_SAR) & v[top];
          v = v >> 1;
          v[top] = msb;
        end
      end
    end
    result = v;
    carryOut = c;
    // Single shifts define overflow; longer ones keep the old value
    if (count == 5'h01) begin
      if (kind == `SBSD_SH_LEFT)
        overflowOut = v[top] ^ c;
      else if (kind == `SBSD_SH_SAR)
        overflowOut = 1'b0;
      else
        overflowOut = operand[top];
    end else begin
      overflowOut = overflowIn;
    end
  end
endmodule

/* File: hdl/sbsd_datapath.v */
// Shift, subtract-with-borrow and string scan execution datapath
`timescale 1ns/1ps
`include "sbsd_map.vh"
// Notes on behaviour
// - Left shift: carry gets top bit, zero fill
// - Right shifts: carry gets bit leaving bottom
// - Arithmetic right keeps top bit each step
// - Logical right clears top bit each step
// - Count from immediate or low count, five bits
// - Count one left: overflow = top xor carry
// - Count one arithmetic right clears overflow
// - Count one logical right: overflow = old top
// - Zero, sign and parity follow shifted result; aux kept
// - Subtract source plus carry, write destination
// - Byte immediate sign-extended to destination width
// - Borrow subtract opcodes 18-1D, 80/81/83 reg 3
// - Borrow subtract and scan set six flags
// - Scan compares accumulator minus memory, flags only
// - Scan always reads the extra data segment
// - Address size picks 16 or 32-bit index
// - Scan address only from destination index
// - Step index by size, direction flag sets sign
// - Repeat prefixes iterate over count register
// - Protected mode faults incl. alignment at level 3
// - Real mode: offset past 0FFFFH gives vector 13
// - Scan opcodes AE/AF, six clocks each
// - Shift opcodes D0-D3, C0-C1, reg 4/5/7
module sbsd_datapath (
  input wire core_clk,
  input wire rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire memRead,
  output reg [31:0] memAddr,
  output wire [2:0] memSegment,
  output reg [1:0] memSize,
  input wire [31:0] memReadData,
  input wire memValid,
  input wire [2:0] memFault,
  input wire segReadOnly
);
  // ----------------
  // States, one-hot
  // ----------------
  localparam S_IDLE = 5'h01;
  localparam S_EXEC = 5'h02;
  localparam S_ADDR = 5'h04;
  localparam S_READ = 5'h08;
  localparam S_PAD = 5'h10;
  // ----------------
  // Helper functions
  // ----------------
  // Mask of live bits for an operand size
  function [31:0] szMask;
    input [1:0] sz;
    begin
      szMask = (sz == `SBSD_SZ_BYTE) ? 32'h000000FF :
        (sz == `SBSD_SZ_WORD) ? 32'h0000FFFF : 32'hFFFFFFFF;
    end
  endfunction
  // Sign bit of a value at a size
  function signOf;
    input [31:0] v;
    input [1:0] sz;
    begin
      signOf = (sz == `SBSD_SZ_BYTE) ? v[7] : (sz == `SBSD_SZ_WORD) ? v[15] : v[31];
    end
  endfunction
  // Zero, sign, parity into a flag word
  function [31:0] zspFlags;
    input [31:0] f;
    input [31:0] v;
    input [1:0] sz;
    reg [31:0] t;
    begin
      t = f;
      t[`SBSD_F_ZERO] = ((v & szMask(sz)) == 32'h00000000);
      t[`SBSD_F_SIGN] = signOf(v, sz);
      t[`SBSD_F_PARITY] = ~^v[7:0];
      zspFlags = t;
    end
  endfunction
  // ----------------
  // Registers
  // ----------------
  reg [31:0] ctrl_r; // Opcode, reg field and modes
  reg [31:0] opA_r; // Destination or accumulator
  reg [31:0] opB_r; // Source or immediate
  reg [31:0] count_r; // Low count and repeat count
  reg [31:0] dIdx_r; // Destination index
  reg [31:0] flags_r; // Flag word
  reg [31:0] result_r; // Last written result
  reg [2:0] fault_r; // Fault code of last operation
  reg badOp_r; // Opcode not handled here
  reg done_r; // Operation finished
  reg [4:0] state_r; // Engine state
  reg [2:0] cyc_r; // Cycle within a scan element
  reg [31:0] memData_r; // Fetched scan element
  reg ack_r; // Bus answer phase
  // ----------------
  // Decode of the loaded instruction
  // ----------------
  wire [7:0] opc = ctrl_r[`SBSD_CT_OPC];
  wire [2:0] regF = ctrl_r[`SBSD_CT_REG];
  wire [1:0] rep = ctrl_r[`SBSD_CT_REP];
  wire ad32 = ctrl_r[`SBSD_CT_AD32];
  wire prot = ctrl_r[`SBSD_CT_PROT];
  wire isShOp = (opc[7:2] == 6'h34) | (opc[7:1] == 7'h60);
  wire isShift = isShOp & ((regF == 3'h4) | (regF == 3'h5) | (regF == 3'h7));
  wire isSbbGrp = ((opc == 8'h80) | (opc == 8'h81) | (opc == 8'h83)) & (regF == 3'h3);
  wire isSbb = isSbbGrp | ((opc >= 8'h18) & (opc <= 8'h1D));
  wire isScan = (opc[7:1] == 7'h57);
  // Low opcode bit picks byte versus wide on every handled form
  wire [1:0] size = ~opc[0] ? `SBSD_SZ_BYTE :
    (ctrl_r[`SBSD_CT_OP32] ? `SBSD_SZ_DWORD : `SBSD_SZ_WORD);
  wire [31:0] mask = szMask(size);
  // ----------------
  // Shifter
  // ----------------
  // Count: 1 for D0/D1, low count for D2/D3, immediate for C0/C1
  wire [7:0] rawCnt = (opc[7:1] == 7'h68) ? 8'h01 :
    (opc[7:1] == 7'h69) ? count_r[7:0] : opB_r[7:0];
  wire [4:0] shCnt = rawCnt[4:0];
  wire [1:0] shKind = (regF == 3'h4) ? `SBSD_SH_LEFT :
    (regF == 3'h7) ? `SBSD_SH_SAR : `SBSD_SH_SHR;
  wire [31:0] shRes;
  wire shCarry;
  wire shOver;
  sbsd_shifter u_shift (
    .operand(opA_r),
    .size(size),
    .kind(shKind),
    .count(shCnt),
    .carryIn(flags_r[`SBSD_F_CARRY]),
    .overflowIn(flags_r[`SBSD_F_OVER]),
    .result(shRes),
    .carryOut(shCarry),
    .overflowOut(shOver)
  );
  // ----------------
  // Subtractor shared by borrow subtract and scan
  // ----------------
  wire [31:0] sbbSrc = (opc == 8'h83) ? {{24{opB_r[7]}}, opB_r[7:0]} : opB_r;
  wire [31:0] subA = opA_r & mask;
  wire [31:0] subB = isScan ? (memData_r & mask) : (sbbSrc & mask);
  wire subCin = isScan ? 1'b0 : flags_r[`SBSD_F_CARRY];
  wire [32:0] diff = {1'b0, subA} - {1'b0, subB} - {32'h00000000, subCin};
  wire [31:0] subRes = diff[31:0] & mask;
  // Borrow is the bit just above the operand size
  wire subBorrow = (size == `SBSD_SZ_BYTE) ? diff[8] :
    (size == `SBSD_SZ_WORD) ? diff[16] : diff[32];
  wire sA = signOf(subA, size);
  wire sB = signOf(subB, size);
  wire sR = signOf(subRes, size);
  reg [31:0] subFlags; // Six arithmetic flags from the difference
  always @* begin
    subFlags = zspFlags(flags_r, subRes, size);
    subFlags[`SBSD_F_CARRY] = subBorrow;
    subFlags[`SBSD_F_AUX] = subA[4] ^ subB[4] ^ subRes[4];
    subFlags[`SBSD_F_OVER] = (sA ^ sB) & (sR ^ sA);
  end
  // ----------------
  // Scan addressing and checks
  // ----------------
  wire [31:0] scanAddr = ad32 ? dIdx_r : {16'h0000, dIdx_r[15:0]};
  wire [2:0] nBytes = (size == `SBSD_SZ_BYTE) ? 3'h1 : (size == `SBSD_SZ_WORD) ? 3'h2 : 3'h4;
  wire [32:0] lastByte = {1'b0, scanAddr} + {30'h00000000, nBytes} - 33'h000000001;
  wire realBad = ~prot & (lastByte > `SBSD_REAL_LIMIT);
  wire misAlign = ((size == `SBSD_SZ_WORD) & scanAddr[0]) |
    ((size == `SBSD_SZ_DWORD) & (scanAddr[1:0] != 2'h0));
  wire alignBad = prot & (ctrl_r[`SBSD_CT_CPL] == 2'h3) & misAlign;
  // Signed step: 1, 2 or 4, negated when direction flag is set
  wire [31:0] step = flags_r[`SBSD_F_DIR] ? (32'h00000000 - {29'h00000000, nBytes}) :
    {29'h00000000, nBytes};
  wire [31:0] idxSum = dIdx_r + step;
  wire [31:0] idxNext = ad32 ? idxSum : {dIdx_r[31:16], idxSum[15:0]};
  // Count register width follows address size
  wire [31:0] cntDec = count_r - 32'h00000001;
  wire [31:0] cntNext = ad32 ? cntDec : {count_r[31:16], cntDec[15:0]};
  wire cntZero = ad32 ? (count_r == 32'h00000000) : (count_r[15:0] == 16'h0000);
  wire cntNextZero = ad32 ? (cntNext == 32'h00000000) : (cntNext[15:0] == 16'h0000);
  wire repOn = (rep == `SBSD_REP_EQ) | (rep == `SBSD_REP_NE);
  // Repeat stops on exhausted count or on the zero-flag condition
  wire repMore = repOn & ~cntNextZero &
    ((rep == `SBSD_REP_EQ) ? subFlags[`SBSD_F_ZERO] : ~subFlags[`SBSD_F_ZERO]);
  // ----------------
  // Bus handshake: one wait cycle on every access
  // ----------------
  wire busReq = avs_read | avs_write;
  assign avs_waitrequest = busReq & ~ack_r;
  wire busWr = avs_write & ack_r;
  wire busy = (state_r != S_IDLE);
  wire goCmd = busWr & (avs_address == `SBSD_REG_CMD) & avs_writedata[0] & ~busy;
  // ----------------
  // Memory port
  // ----------------
  assign memRead = (state_r == S_READ);
  assign memSegment = `SBSD_SEG_EXTRA;
  // ----------------
  // Read data mux, loaded in the wait cycle
  // ----------------
  reg [31:0] rdMux; // Selected register
  always @* begin
    case (avs_address)
      `SBSD_REG_CTRL: rdMux = ctrl_r;
      `SBSD_REG_OPA: rdMux = opA_r;
      `SBSD_REG_OPB: rdMux = opB_r;
      `SBSD_REG_COUNT: rdMux = count_r;
      `SBSD_REG_DIDX: rdMux = dIdx_r;
      `SBSD_REG_FLAGS: rdMux = flags_r;
      `SBSD_REG_RESULT: rdMux = result_r;
      `SBSD_REG_STATUS: rdMux = {16'h0000,
        (fault_r == `SBSD_FLT_REAL) ? `SBSD_REAL_VECTOR : 8'h00,
        1'b0, fault_r, 1'b0, badOp_r, done_r, busy};
      default: rdMux = 32'h00000000; // Unmapped reads zero
    endcase
  end
  // ----------------
  // Bus side flops
  // ----------------
  always @(posedge core_clk) begin
    if (rst) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_r <= busReq & ~ack_r;
      if (avs_read & ~ack_r)
        avs_readdata <= rdMux;
    end
  end
  // ----------------
  // Register file and engine
  // ----------------
  always @(posedge core_clk) begin
    if (rst) begin
      ctrl_r <= `SBSD_CTRL_RST;
      opA_r <= 32'h00000000;
      opB_r <= 32'h00000000;
      count_r <= 32'h00000000;
      dIdx_r <= 32'h00000000;
      flags_r <= 32'h00000000;
      result_r <= 32'h00000000;
      fault_r <= `SBSD_FLT_NONE;
      badOp_r <= 1'b0;
      done_r <= 1'b0;
      state_r <= S_IDLE;
      cyc_r <= 3'h0;
      memData_r <= 32'h00000000;
      memAddr <= 32'h00000000;
      memSize <= `SBSD_SZ_BYTE;
    end else begin
      // Writes land only while idle, so operands stay steady mid-run
      if (busWr & ~busy) begin
        case (avs_address)
          `SBSD_REG_CTRL: ctrl_r <= avs_writedata;
          `SBSD_REG_OPA: opA_r <= avs_writedata;
          `SBSD_REG_OPB: opB_r <= avs_writedata;
          `SBSD_REG_COUNT: count_r <= avs_writedata;
          `SBSD_REG_DIDX: dIdx_r <= avs_writedata;
          `SBSD_REG_FLAGS: flags_r <= avs_writedata & `SBSD_FLAGS_MASK;
          default: ;
        endcase
      end
      case (state_r)
        S_IDLE: begin
          if (goCmd) begin
            done_r <= 1'b0;
            badOp_r <= 1'b0;
            fault_r <= `SBSD_FLT_NONE;
            cyc_r <= 3'h0;
            if (isShift | isSbb) begin
              state_r <= S_EXEC;
            end else if (isScan) begin
              // Repeat with an empty count does nothing
              if (repOn & cntZero) begin
                done_r <= 1'b1;
              end else begin
                state_r <= S_ADDR;
              end
            end else begin
              badOp_r <= 1'b1;
              done_r <= 1'b1;
            end
          end
        end
        S_EXEC: begin
          state_r <= S_IDLE;
          done_r <= 1'b1;
          if (prot & ctrl_r[`SBSD_CT_MEMDST] & segReadOnly) begin
            fault_r <= `SBSD_FLT_GP;
          end else if (isShift) begin
            if (shCnt != 5'h00) begin
              opA_r <= (opA_r & ~mask) | shRes;
              result_r <= shRes;
              flags_r <= {zspFlags(flags_r, shRes, size)} & ~32'h00000801 |
                {20'h00000, shOver, 10'h000, shCarry};
            end
          end else begin
            opA_r <= (opA_r & ~mask) | subRes;
            result_r <= subRes;
            flags_r <= subFlags;
          end
        end
        S_ADDR: begin
          cyc_r <= cyc_r + 3'h1;
          memAddr <= scanAddr;
          memSize <= size;
          if (realBad) begin
            fault_r <= `SBSD_FLT_REAL;
            done_r <= 1'b1;
            state_r <= S_IDLE;
          end else if (alignBad) begin
            fault_r <= `SBSD_FLT_ALIGN;
            done_r <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            state_r <= S_READ;
          end
        end
        S_READ: begin
          if (cyc_r != 3'h7) // Saturate so slow data cannot wrap the element count
            cyc_r <= cyc_r + 3'h1;
          if (memValid) begin
            if (prot & (memFault != 3'h0)) begin
              // Page beats stack beats segment when several report
              fault_r <= memFault[2] ? `SBSD_FLT_PAGE :
                memFault[1] ? `SBSD_FLT_STACK : `SBSD_FLT_GP;
              done_r <= 1'b1;
              state_r <= S_IDLE;
            end else begin
              memData_r <= memReadData;
              state_r <= S_PAD;
            end
          end
        end
        S_PAD: begin
          cyc_r <= cyc_r + 3'h1;
          // Compare on the sixth cycle of the element
          if (cyc_r >= `SBSD_SCAN_CLOCKS - 3'h1) begin
            flags_r <= subFlags;
            dIdx_r <= idxNext;
            cyc_r <= 3'h0;
            if (repOn)
              count_r <= cntNext;
            if (repMore) begin
              state_r <= S_ADDR;
            end else begin
              state_r <= S_IDLE;
              done_r <= 1'b1;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule

/* File: test/sbsd_datapath_asserts.sv */
// Port-level checks of the execution datapath
`timescale 1ns/1ps
module sbsd_checker (
  input wire core_clk,
  input wire rst,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire memRead,
  input wire [31:0] memAddr,
  input wire [2:0] memSegment,
  input wire [1:0] memSize,
  input wire memValid
);
  // ----------------------------------------
  // Bus and fetch properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // First cycle of every access must stall
  a_first_wait: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
    |-> avs_waitrequest) else $error("no wait in first bus cycle");
  // Never more than one wait cycle
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("second wait cycle");
  a_extra_seg: assert property (memSegment == 3'h0)
    else $error("fetch outside extra data segment");
  a_addr_load: assert property (memRead |=> $stable(memAddr))
    else $error("address moved during fetch");
  a_addr_hold: assert property (memRead && !memValid |=> memRead && $stable(memAddr)
    && $stable(memSize)) else $error("fetch dropped or moved");
  // Prompt data still pads the element out to its full length
  a_scan_pad: assert property ($rose(memRead) && memValid |=> !memRead [*5])
    else $error("element finished early");
  a_scan_gap: assert property (memRead && memValid |=> !memRead [*2])
    else $error("fetch kept after data");
  a_elem_size: assert property (memRead |-> memSize <= 2'h2)
    else $error("bad element size");
  c_prompt: cover property ($rose(memRead) && memValid);
  c_slow: cover property (memRead && !memValid ##1 memRead && memValid);
  c_write: cover property (avs_write && !avs_waitrequest);
endmodule
bind sbsd_datapath sbsd_checker u_chk (.core_clk(core_clk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .memRead(memRead),
  .memAddr(memAddr), .memSegment(memSegment), .memSize(memSize), .memValid(memValid));

/* File: test/sbsd_mem_model.sv */
// Operand memory path answering scan element fetches
`timescale 1ns/1ps
module sbsd_mem_model (
  input wire core_clk,
  input wire rst,
  input wire memRead,
  input wire [31:0] memAddr,
  input wire [3:0] lag,
  input wire [2:0] faultIn,
  output wire [31:0] memReadData,
  output wire memValid,
  output wire [2:0] memFault
);
  reg [3:0] waitCnt_r; // Cycles the fetch has waited
  reg [7:0] junk_r; // Changes every cycle so stale data is never trusted
  assign memValid = memRead && waitCnt_r >= lag;
  assign memReadData = memValid ? {memAddr[23:0], ~memAddr[7:0]} : {4{junk_r}};
  assign memFault = memValid ? faultIn : 3'h0;
  // Wait counter restarts for every fetch
  always @(posedge core_clk) begin
    junk_r <= rst ? 8'h5A : junk_r + 8'h3B;
    waitCnt_r <= rst || !memRead || memValid ? 4'h0 : waitCnt_r + 4'h1;
  end
endmodule

/* File: test/sbsd_datapath_tb.sv */
// Self-checking bench for the execution datapath
`timescale 1ns/1ps
`include "sbsd_map.vh"
module sbsd_datapath_tb;
  // ----------------------------------------
  // Signals and scoreboard
  // ----------------------------------------
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] avsAddr = 4'h0;
  reg avsRead = 1'b0;
  reg avsWrite = 1'b0;
  reg [31:0] avsData = 32'h0;
  reg segRo = 1'b0;
  reg [3:0] lag = 4'h0;
  reg [2:0] fltIn = 3'h0;
  wire [31:0] rdData, memAddr, memData;
  wire avsWait, memRead, memValid;
  wire [2:0] memSeg, memFault;
  wire [1:0] memSize;
  integer num_errors = 0;
  integer checks = 0;
  integer seed = 9;
  integer i, j;
  reg [63:0] notes[$]; // Mask and expected value per read
  reg [63:0] e, nt;
  reg [31:0] a, b, fl, q;
  reg [7:0] op;
  reg [1:0] k, sz;
  reg [4:0] n;
  reg w32;
  always #20 core_clk = ~core_clk;
  sbsd_datapath DUT (.core_clk(core_clk), .rst(rst), .avs_address(avsAddr),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsData),
    .avs_readdata(rdData), .avs_waitrequest(avsWait), .memRead(memRead),
    .memAddr(memAddr), .memSegment(memSeg), .memSize(memSize), .memReadData(memData),
    .memValid(memValid), .memFault(memFault), .segReadOnly(segRo));
  sbsd_mem_model u_mem (.core_clk(core_clk), .rst(rst), .memRead(memRead),
    .memAddr(memAddr), .lag(lag), .faultIn(fltIn), .memReadData(memData),
    .memValid(memValid), .memFault(memFault));
  function [31:0] wm(input [1:0] s);
    wm = s == 2'h0 ? 32'hFF : s == 2'h1 ? 32'hFFFF : 32'hFFFFFFFF;
  endfunction
  // Parity, zero and sign of a masked result
  function [31:0] szp(input [31:0] r, input integer t);
    begin
      szp = 32'h0;
      szp[2] = ~^r[7:0];
      szp[6] = r == 32'h0;
      szp[7] = r[t];
    end
  endfunction
  function [63:0] subtract_with_borrow(input [31:0] x, input [31:0] y, input ci, input [1:0] s);
    reg [32:0] d;
    reg [31:0] r, f;
    integer t;
    begin
      t = (8 << s) - 1;
      d = {1'b0, x & wm(s)} - {1'b0, y & wm(s)} - ci;
      r = d[31:0] & wm(s);
      f = szp(r, t);
      f[0] = d[t + 1];
      f[4] = x[4] ^ y[4] ^ r[4];
      f[11] = (x[t] ^ y[t]) & (x[t] ^ r[t]);
      subtract_with_borrow = {f, r};
    end
  endfunction
  // Stepwise shift; aux always kept, overflow kept unless one step
  function [63:0] shf(input [1:0] h, input [31:0] v, input [4:0] c, input [1:0] s,
    input [31:0] fi);
    reg [31:0] r, f;
    reg top;
    integer t, m;
    begin
      t = (8 << s) - 1;
      r = v & wm(s);
      f = fi;
      for (m = 0; m < c; m = m + 1) begin
        top = r[t];
        f[0] = h == 2'h0 ? top : r[0];
        r = h == 2'h0 ? (r << 1) & wm(s) : r >> 1;
        if (h != 2'h0) r[t] = h == 2'h1 & top;
      end
      if (c != 5'h0) begin
        f = (f & 32'hFFFFFF3B) | szp(r, t);
        if (c == 5'h1) f[11] = h == 2'h0 ? r[t] ^ f[0] : h == 2'h2 & v[t];
      end
      shf = {f, r};
    end
  endfunction
  task check(input [31:0] seen, input [31:0] exp, input [3:0] idx);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value reg %0d expected %h seen %h", idx, exp, seen);
      end
    end
  endtask
  // One bus transfer, held until waitrequest is sampled low
  task bus(input w, input [3:0] ad, input [31:0] d, input [63:0] x);
    begin
      @(posedge core_clk);
      if (!w) notes.push_back(x);
      avsAddr <= ad;
      avsRead <= !w;
      avsWrite <= w;
      avsData <= d;
      @(posedge core_clk);
      while (avsWait !== 1'b0) @(posedge core_clk);
      q = rdData;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
    end
  endtask
  task wr(input [3:0] ad, input [31:0] d);
    bus(1'b1, ad, d, 64'h0);
  endtask
  task rd(input [3:0] ad, input [31:0] m, input [31:0] x);
    bus(1'b0, ad, 32'h0, {m, x & m});
  endtask
  // Oldest note is matched against each completed read
  always @(posedge core_clk) begin
    if (avsRead && avsWait === 1'b0 && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt[63:32] != 32'h0) check(rdData & nt[63:32], nt[31:0], avsAddr);
    end
  end
  task load(input [31:0] x, input [31:0] y, input [31:0] c, input [31:0] f);
    begin
      wr(`SBSD_REG_OPA, x);
      wr(`SBSD_REG_OPB, y);
      wr(`SBSD_REG_COUNT, c);
      wr(`SBSD_REG_FLAGS, f);
    end
  endtask
  // Start an operation and poll until done
  task run(input [31:0] ctl);
    begin
      wr(`SBSD_REG_CTRL, ctl);
      wr(`SBSD_REG_CMD, 32'h1);
      q = 32'h0;
      while (q[1] !== 1'b1) rd(`SBSD_REG_STATUS, 32'h0, 32'h0);
    end
  endtask
  task scan(input [31:0] ctl, input [31:0] acc, input [31:0] di, input [31:0] c,
    input [31:0] f, input [3:0] lg, input [2:0] ft, input [2:0] fx);
    reg [31:0] ad, fo, st, nn;
    reg go;
    begin
      wr(`SBSD_REG_DIDX, di);
      load(acc, 32'h0, c, f);
      lag <= lg;
      fltIn <= ft;
      run(ctl);
      sz = ctl[7:0] == 8'hAE ? 2'h0 : {ctl[12], !ctl[12]};
      st = f[10] ? -(32'h1 << sz) : 32'h1 << sz;
      nn = ctl[13] ? c : c & 32'hFFFF;
      fo = f;
      go = ctl[18:17] == 2'h0 || nn != 32'h0;
      while (go && fx == 3'h0) begin
        ad = ctl[13] ? di : di & 32'hFFFF;
        e = subtract_with_borrow(acc, {ad[23:0], ~ad[7:0]}, 1'b0, sz);
        fo = e[63:32] | (f & 32'h400);
        di = ctl[13] ? di + st : {di[31:16], di[15:0] + st[15:0]};
        nn = nn - (ctl[18:17] != 2'h0);
        go = ctl[18:17] != 2'h0 && nn != 32'h0 && e[38] == ctl[17];
      end
      rd(`SBSD_REG_STATUS, 32'hFFFF, {fx == 3'h5 ? 8'h0D : 8'h0, 1'b0, fx, 4'h2});
      rd(`SBSD_REG_DIDX, 32'hFFFFFFFF, di);
      rd(`SBSD_REG_FLAGS, 32'hCD5, fo);
      rd(`SBSD_REG_OPA, 32'hFFFFFFFF, acc);
      rd(`SBSD_REG_COUNT, ctl[13] ? 32'hFFFFFFFF : 32'hFFFF, nn);
    end
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    for (i = 5; i < 8; i = i + 1) rd(i[3:0], 32'hFFFFFFFF, 32'h0);
    wr(4'hF, 32'hFFFFFFFF);
    wr(`SBSD_REG_RESULT, 32'hFFFFFFFF);
    rd(4'hF, 32'hFFFFFFFF, 32'h0);
    rd(`SBSD_REG_RESULT, 32'hFFFFFFFF, 32'h0);
    $display("register test done");
    // Random counts, then masked zero and masked one
    for (j = 0; j < 3; j = j + 1)
      for (i = 0; i < 18; i = i + 1) begin
        a = $random(seed);
        b = j == 0 ? $random(seed) : 32'hE0 | (j - 1);
        fl = $random(seed) & 32'hCD5;
        w32 = $random(seed);
        op = i % 6 < 2 ? 8'hC0 + i % 6 : 8'hCE + i % 6;
        k = i / 6;
        sz = op[0] ? {w32, !w32} : 2'h0;
        n = op[4] && !op[1] ? 5'h1 : b[4:0];
        load(a, b, b, fl);
        run({w32, 1'b0, k == 2'h0 ? 3'h4 : k == 2'h1 ? 3'h7 : 3'h5, op});
        e = shf(k, a, n, sz, fl);
        rd(`SBSD_REG_OPA, 32'hFFFFFFFF, (a & ~wm(sz)) | e[31:0]);
        rd(`SBSD_REG_FLAGS, 32'hCD5, e[63:32]);
      end
    $display("shift test done");
    for (i = 0; i < 18; i = i + 1) begin
      op = 72'h1C1D80818318191A1B >> (8 * (8 - i % 9));
      a = $random(seed);
      b = $random(seed);
      fl = $random(seed) & 32'hCD5;
      w32 = $random(seed);
      sz = op[0] ? {w32, !w32} : 2'h0;
      load(a, b, 32'h0, fl);
      run({w32, 1'b0, op[7] ? 3'h3 : 3'h0, op});
      e = subtract_with_borrow(a, op == 8'h83 ? {{24{b[7]}}, b[7:0]} : b, fl[0], sz);
      rd(`SBSD_REG_OPA, 32'hFFFFFFFF, (a & ~wm(sz)) | e[31:0]);
      rd(`SBSD_REG_FLAGS, 32'hCD5, e[63:32] | (fl & 32'h400));
    end
    // Undecodable opcode, then a write to a read-only segment
    run(32'h27);
    rd(`SBSD_REG_STATUS, 32'hFFFFFFFF, 32'h6);
    segRo <= 1'b1;
    run(32'h844D1);
    rd(`SBSD_REG_STATUS, 32'hFFFF, 32'h12);
    rd(`SBSD_REG_OPA, 32'hFFFFFFFF, (a & ~wm(sz)) | e[31:0]);
    segRo <= 1'b0;
    $display("borrow test done");
    scan(32'hAE, a, 32'hABCD0100, 32'h0, 32'h0, 4'h0, 3'h0, 3'h0);
    scan(32'h20AF, a, 32'h200, 32'h0, 32'h400, 4'h6, 3'h0, 3'h0);
    scan(32'h30AF, 32'h404FB, 32'h404, 32'h0, 32'h0, 4'h2, 3'h0, 3'h0);
    scan(32'h200AE, a, 32'h100, 32'hFFFF0003, 32'h0, 4'h1, 3'h0, 3'h0);
    scan(32'h420AE, a, 32'h300, 32'h3, 32'h400, 4'h0, 3'h0, 3'h0);
    scan(32'h200AE, a, 32'h100, 32'h0, 32'h0, 4'h0, 3'h0, 3'h0);
    scan(32'h20AF, a, 32'hFFFF, 32'h0, 32'h0, 4'h0, 3'h0, 3'h5);
    scan(32'h1F0AF, a, 32'h102, 32'h0, 32'h0, 4'h0, 3'h0, 3'h4);
    for (i = 0; i < 3; i = i + 1) scan(32'h70AF, a, 32'h104, 32'h0, 32'h0, 4'h0, 3'h4 >> i, 3'h3 - i);
    $display("scan test done");
    conclude;
  end
  initial begin
    #800000;
    num_errors = num_errors + 1;
    conclude;
  end
  task conclude;
    begin
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
endmodule
